//--- include/dsf_pkg.sv
// Purpose: Shared constants and types for the acquisition status flag block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes: Status words are 16 bits wide and sit in the low half of the bus word

package dsf_pkg;

   // Register byte addresses
   localparam logic [7:0] DSF_ADDR_STATUS1 = 8'h18; // Board status flags
   localparam logic [7:0] DSF_ADDR_STATUS2 = 8'h1A; // ADC busy status, index form
   localparam logic [7:0] DSF_ADDR_BUSY = 8'h1A; // Byte address of the ADC busy word
   localparam logic [7:0] DSF_ADDR_CTRL = 8'h20; // Mode control word
   localparam logic [7:0] DSF_ADDR_CLEAR = 8'h24; // Clear strobe word, write one to clear

   // Status register 1 bit positions
   localparam int DSF_B_ADC_NE = 12; // ADC FIFO not empty, active low empty
   localparam int DSF_B_DMA_A = 11; // DMA channel A done
   localparam int DSF_B_DMA_B = 10; // DMA channel B done
   localparam int DSF_B_OVFL = 9; // ADC FIFO overflow
   localparam int DSF_B_OVRN = 8; // Conversion overrun
   localparam int DSF_B_TREQ = 7; // Timer update request
   localparam int DSF_B_DDONE = 6; // DAC sequence done
   localparam int DSF_B_DFULL = 5; // DAC FIFO full, active low
   localparam int DSF_B_DHALF = 4; // DAC FIFO half, active low
   localparam int DSF_B_DEMPTY = 3; // DAC FIFO empty, active low
   localparam int DSF_B_PDATA = 2; // Serial PROM data
   localparam int DSF_B_PDESEL = 1; // PROM deselect, active low
   localparam int DSF_B_CFG = 0; // Config memory empty, active low

   // Clear strobe word bit positions
   localparam int DSF_C_DMA_A = 0; // Clear channel A done
   localparam int DSF_C_DMA_B = 1; // Clear channel B done
   localparam int DSF_C_DAQ = 2; // Acquisition clear
   localparam int DSF_C_TREQ = 3; // Timer request clear
   localparam int DSF_C_DAC = 4; // DAC clear
   localparam int DSF_C_CAL = 5; // Start ADC calibration

   // Control word bit positions
   localparam int DSF_K_MODE_LO = 0; // DAC request mode, two bits
   localparam int DSF_K_ADC_IE = 2; // ADC conversion interrupt enable
   localparam int DSF_K_DAC_IE = 3; // DAC complete interrupt enable

   // Reset values
   localparam logic [3:0] DSF_CTRL_RST = 4'h0; // Programmed mode, no enables

   // Calibration time
   localparam real DSF_CAL_SEC = 1.25; // Calibration time in seconds
   localparam real DSF_CLK_HZ = 250.0e6; // Clock rate
   localparam int DSF_CAL_CYC = int'(DSF_CAL_SEC * DSF_CLK_HZ); // Calibration cycles

   // DAC request modes
   typedef enum logic [1:0]
   {
      DSF_MODE_PROG,
      DSF_MODE_IRQ,
      DSF_MODE_DMA,
      DSF_MODE_RSVD
   } dsf_mode_type;

   // Calibration sequencer states
   typedef enum logic
   {
      DSF_CAL_IDLE,
      DSF_CAL_RUN
   } dsf_cal_type;

   // Hardware event inputs from the rest of the board
   typedef struct packed
   {
      logic adc_fifo_has_data; // ADC FIFO holds results
      logic adc_fifo_full; // ADC FIFO full
      logic conv_done; // Conversion finished pulse
      logic conv_start; // Conversion start pulse
      logic adc_converting; // Converter busy converting
      logic dma_tc_a; // DMA channel A terminal count pulse
      logic dma_tc_b; // DMA channel B terminal count pulse
      logic dac_fifo_full; // DAC FIFO full
      logic dac_fifo_half; // DAC FIFO at least half full
      logic dac_fifo_empty; // DAC FIFO empty
      logic dac_write; // Any DAC write pulse
      logic dac_seq_run; // DAC sequence running
      logic cfg_mem_has_data; // Config memory holds entries
   } dsf_events_type;

   // Whole block state
   typedef struct packed
   {
      logic [3:0] ctrl; // Mode control word
      logic dma_done_chan_a; // Sticky DMA A done
      logic dma_done_chan_b; // Sticky DMA B done
      logic overflow; // Sticky overflow
      logic overrun; // Sticky overrun
      logic timer_update_request; // Timer request flag
      logic dac_sequence_done; // DAC sequence done flag
      logic seq_run_q; // Last sequence run level
      logic trig_q; // Last synced trigger level
      logic conv_busy; // A conversion is in flight
      dsf_cal_type cal_state; // Calibration state
      logic [31:0] cal_cnt; // Calibration countdown
      logic ack; // Bus acknowledge
      logic [31:0] rdata; // Bus read data
      logic [1:0] trig_sync; // Trigger synchroniser
      logic [1:0] pdata_sync; // PROM data synchroniser
      logic [1:0] pcs_sync; // PROM chip select synchroniser
   } dsf_state_type;

endpackage

//--- design/dsf_status.sv
// Purpose: Read-only status flags of a data acquisition board over Wishbone
// Assumes: One clock, synchronous active-high reset, event inputs on clk_i
// Notes: Reads have no side effect; flags change by clears and hardware events

`timescale 1ns/10ps
`default_nettype none

module dsf_status
#(
   parameter int CAL_CYCLES = dsf_pkg::DSF_CAL_CYC // Calibration length in cycles
)
(
   input wire logic clk_i, // 250 MHz clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [7:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire dsf_pkg::dsf_events_type ev_i, // Board events, same clock
   input wire logic timer_trigger_pulse_n_i, // Trigger pin, active low
   input wire logic prom_serial_out_i, // PROM serial data pin
   input wire logic prom_chip_select_i, // PROM chip select pin
   output logic adc_irq_o, // ADC conversion interrupt request, high while the ADC interrupt enable bit is set and the ADC FIFO holds results
   output logic timer_irq_o, // Timer interrupt request
   output logic timer_dma_o, // Timer DMA request
   output logic dac_done_irq_o, // DAC done interrupt request
   output logic daq_abort_o, // Acquisition stop level
   output logic adc_ready_o // ADC usable for conversions
);

   dsf_pkg::dsf_state_type s; // Registered state
   dsf_pkg::dsf_state_type next_s; // Next state
   logic [15:0] status1; // Status word one
   logic adc_busy; // ADC busy level
   logic req; // Bus request this cycle
   logic wr; // Register write this cycle
   logic [5:0] clr; // Clear strobes this cycle
   logic trig_rise; // Trigger asserted edge
   dsf_pkg::dsf_mode_type mode; // Current DAC request mode

   // Set wins over clear for a sticky flag
   function automatic logic sticky(input logic cur, input logic set, input logic clear);
      sticky = set | (cur & ~clear);
   endfunction

   // Bus and strobe decode
   always_comb
   begin
      req = wb_cyc_i & wb_stb_i & ~s.ack;
      wr = req & wb_we_i;
      clr = '0;
      if (wr && wb_adr_i == dsf_pkg::DSF_ADDR_CLEAR && wb_sel_i[0])
      begin
         clr = wb_dat_i[5:0];
      end
      mode = dsf_pkg::dsf_mode_type'(s.ctrl[1:0]);
      trig_rise = s.trig_sync[1] & ~s.trig_q;
      adc_busy = s.conv_busy | ev_i.adc_converting | (s.cal_state == dsf_pkg::DSF_CAL_RUN);
   end

   // Status word one assembly
   always_comb
   begin
      status1 = '0;
      status1[dsf_pkg::DSF_B_ADC_NE] = ev_i.adc_fifo_has_data;
      status1[dsf_pkg::DSF_B_DMA_A] = s.dma_done_chan_a;
      status1[dsf_pkg::DSF_B_DMA_B] = s.dma_done_chan_b;
      status1[dsf_pkg::DSF_B_OVFL] = s.overflow;
      status1[dsf_pkg::DSF_B_OVRN] = s.overrun;
      status1[dsf_pkg::DSF_B_TREQ] = s.timer_update_request;
      status1[dsf_pkg::DSF_B_DDONE] = s.dac_sequence_done;
      status1[dsf_pkg::DSF_B_DFULL] = ~ev_i.dac_fifo_full;
      status1[dsf_pkg::DSF_B_DHALF] = ~ev_i.dac_fifo_half;
      status1[dsf_pkg::DSF_B_DEMPTY] = ~ev_i.dac_fifo_empty;
      status1[dsf_pkg::DSF_B_PDATA] = s.pdata_sync[1];
      status1[dsf_pkg::DSF_B_PDESEL] = s.pcs_sync[1];
      status1[dsf_pkg::DSF_B_CFG] = ev_i.cfg_mem_has_data;
   end

   // Next state
   always_comb
   begin
      next_s = s;
      // Synchronisers; first stages feed only the second stages
      next_s.trig_sync = {s.trig_sync[0], ~timer_trigger_pulse_n_i};
      next_s.pdata_sync = {s.pdata_sync[0], prom_serial_out_i};
      next_s.pcs_sync = {s.pcs_sync[0], prom_chip_select_i};
      next_s.trig_q = s.trig_sync[1];
      next_s.seq_run_q = ev_i.dac_seq_run;
      // Control register write
      if (wr && wb_adr_i == dsf_pkg::DSF_ADDR_CTRL && wb_sel_i[0])
      begin
         next_s.ctrl = wb_dat_i[3:0];
      end
      // Sticky DMA flags
      next_s.dma_done_chan_a = sticky(s.dma_done_chan_a, ev_i.dma_tc_a, clr[dsf_pkg::DSF_C_DMA_A]);
      next_s.dma_done_chan_b = sticky(s.dma_done_chan_b, ev_i.dma_tc_b, clr[dsf_pkg::DSF_C_DMA_B]);
      // Acquisition errors
      next_s.overflow = sticky(s.overflow, ev_i.conv_done & ev_i.adc_fifo_full,
                               clr[dsf_pkg::DSF_C_DAQ]);
      next_s.overrun = sticky(s.overrun, ev_i.conv_start & (s.conv_busy | ev_i.adc_converting),
                              clr[dsf_pkg::DSF_C_DAQ]);
      // Conversion in flight tracker
      if (ev_i.conv_start)
      begin
         next_s.conv_busy = 1'b1;
      end
      else if (ev_i.conv_done)
      begin
         next_s.conv_busy = 1'b0;
      end
      // Timer request: set on DAC room or trigger in interrupt mode
      next_s.timer_update_request = sticky(s.timer_update_request,
         ~ev_i.dac_fifo_full | (trig_rise & (mode == dsf_pkg::DSF_MODE_IRQ)),
         clr[dsf_pkg::DSF_C_TREQ] | (mode == dsf_pkg::DSF_MODE_DMA & ev_i.dac_write));
      // DAC done: low while running, set at sequence end
      if (ev_i.dac_seq_run)
      begin
         next_s.dac_sequence_done = 1'b0;
      end
      else
      begin
         next_s.dac_sequence_done = sticky(s.dac_sequence_done, s.seq_run_q,
            clr[dsf_pkg::DSF_C_TREQ] | clr[dsf_pkg::DSF_C_DAC]);
      end
      // Calibration sequencer
      case (s.cal_state)
         dsf_pkg::DSF_CAL_IDLE:
         begin
            if (clr[dsf_pkg::DSF_C_CAL])
            begin
               next_s.cal_state = dsf_pkg::DSF_CAL_RUN;
               next_s.cal_cnt = 32'(CAL_CYCLES - 1);
            end
         end
         dsf_pkg::DSF_CAL_RUN:
         begin
            if (s.cal_cnt == 32'h0)
            begin
               next_s.cal_state = dsf_pkg::DSF_CAL_IDLE;
            end
            else
            begin
               next_s.cal_cnt = s.cal_cnt - 32'h1;
            end
         end
         default:
         begin
            next_s.cal_state = dsf_pkg::DSF_CAL_IDLE;
         end
      endcase
      // Bus answer one cycle after request; reads change no flag
      next_s.ack = req;
      next_s.rdata = 32'h0;
      if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            dsf_pkg::DSF_ADDR_STATUS1: next_s.rdata = {16'h0, status1};
            dsf_pkg::DSF_ADDR_BUSY: next_s.rdata = {31'h0, ~adc_busy};
            dsf_pkg::DSF_ADDR_CTRL: next_s.rdata = {28'h0, s.ctrl};
            default: next_s.rdata = 32'h0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.ctrl <= dsf_pkg::DSF_CTRL_RST;
         s.cal_state <= dsf_pkg::DSF_CAL_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs
   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign adc_irq_o = s.ctrl[dsf_pkg::DSF_K_ADC_IE] & ev_i.adc_fifo_has_data;
   assign timer_irq_o = s.timer_update_request & (mode == dsf_pkg::DSF_MODE_IRQ);
   assign timer_dma_o = s.timer_update_request & (mode == dsf_pkg::DSF_MODE_DMA);
   assign dac_done_irq_o = s.ctrl[dsf_pkg::DSF_K_DAC_IE] & s.dac_sequence_done;
   assign daq_abort_o = s.overflow | s.overrun;
   assign adc_ready_o = ~adc_busy;

   // Checks
   a_dma_a_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      s.dma_done_chan_a && !clr[dsf_pkg::DSF_C_DMA_A] |=> s.dma_done_chan_a)
      else $error("dma a flag dropped");
   a_dma_a_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_i.dma_tc_a |=> s.dma_done_chan_a)
      else $error("dma a flag not set");
   a_dma_b_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_i.dma_tc_b |=> s.dma_done_chan_b)
      else $error("dma b flag not set");
   a_ovfl_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_i.conv_done && ev_i.adc_fifo_full |=> s.overflow && daq_abort_o)
      else $error("overflow missed");
   a_ovrn_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      s.overrun && !clr[dsf_pkg::DSF_C_DAQ] |=> s.overrun)
      else $error("overrun dropped");
   a_ovrn_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_i.conv_start && (s.conv_busy || ev_i.adc_converting) |=> s.overrun)
      else $error("overrun missed");
   a_treq_dma_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      mode == dsf_pkg::DSF_MODE_DMA && ev_i.dac_write && ev_i.dac_fifo_full |=> !s.timer_update_request)
      else $error("timer request not cleared");
   a_treq_room: assert property (@(posedge clk_i) disable iff (rst_i)
      !ev_i.dac_fifo_full |=> s.timer_update_request)
      else $error("timer request not set");
   a_dac_run_low: assert property (@(posedge clk_i) disable iff (rst_i)
      ev_i.dac_seq_run |=> !s.dac_sequence_done)
      else $error("dac done high while running");
   a_dac_end_set: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(ev_i.dac_seq_run) |=> s.dac_sequence_done)
      else $error("dac done not set at end");
   a_dac_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      clr[dsf_pkg::DSF_C_DAC] && !ev_i.dac_seq_run && !s.seq_run_q |=> !s.dac_sequence_done)
      else $error("dac done not cleared");
   a_cal_busy: assert property (@(posedge clk_i) disable iff (rst_i)
      s.cal_state == dsf_pkg::DSF_CAL_IDLE && clr[dsf_pkg::DSF_C_CAL] |=> !adc_ready_o [*8])
      else $error("calibration not busy");
   a_adc_empty: assert property (@(posedge clk_i) disable iff (rst_i)
      !ev_i.adc_fifo_has_data |-> !adc_irq_o)
      else $error("adc request while empty");
   a_read_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !wb_we_i |=> $stable(s.dma_done_chan_a) || $past(ev_i.dma_tc_a))
      else $error("read changed a flag");

endmodule

`default_nettype wire

//--- testbench/dsf_host_model.sv
// Purpose: Host software model issuing classic Wishbone single cycles
// Assumes: The slave answers every request with a one-cycle ack
// Notes: Released address, data and direction show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module dsf_host_model
(
   input wire logic clk_i, // Bus clock
   input wire logic [31:0] dat_i, // Read data from slave
   input wire logic ack_i, // Slave acknowledge
   output logic cyc_o, // Cycle
   output logic stb_o, // Strobe
   output logic we_o, // Write enable
   output logic [7:0] adr_o, // Byte address
   output logic [3:0] sel_o, // Byte selects
   output logic [31:0] dat_o // Write data
);
   // Idle bus from time zero
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // One cycle, held whole until ack is sampled high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      // Release; address, data and direction are inverted, selects keep their last value
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= ~w;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the acquisition status flag block
// Assumes: Calibration shortened to a small cycle count
// Notes: Expected status is rebuilt from event inputs and tracked sticky flags
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int CAL = 20; // Shortened calibration length
   localparam logic [12:0] M_CDONE = 13'h0400; // Conversion done event
   localparam logic [12:0] M_CSTART = 13'h0200; // Conversion start event
   localparam logic [12:0] M_DMA_A = 13'h0080; // DMA A terminal count
   localparam logic [12:0] M_DMA_B = 13'h0040; // DMA B terminal count
   localparam logic [12:0] M_DWR = 13'h0004; // DAC write event
   logic clk_i = 1'b0; // Bench clock
   logic rst_i = 1'b1; // Reset, held at start
   logic cyc, stb, we, ack; // Bus controls
   logic [7:0] adr; // Bus address
   logic [3:0] sel; // Bus selects
   logic [31:0] wdat, rdat, q; // Bus data and last read
   dsf_pkg::dsf_events_type ev = '0; // Board events
   logic trig_n = 1'b1; // Trigger pin, idle high
   logic pdata = 1'b0; // PROM data pin
   logic pcs = 1'b0; // PROM select pin
   logic adc_irq, t_irq, t_dma, d_irq, abort, ready; // Request outputs
   logic [5:0] st = 6'h00; // Expected sticky flags, bits 11 down to 6
   int err_total = 0; // Mismatch count
   int n_compared = 0; // Comparison count

   // Clock, 4 ns period
   always #2 clk_i = ~clk_i;

   dsf_host_model host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));

   dsf_status #(.CAL_CYCLES(CAL)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .ev_i(ev), .timer_trigger_pulse_n_i(trig_n), .prom_serial_out_i(pdata), .prom_chip_select_i(pcs),
      .adc_irq_o(adc_irq), .timer_irq_o(t_irq), .timer_dma_o(t_dma), .dac_done_irq_o(d_irq),
      .daq_abort_o(abort), .adc_ready_o(ready));

   // Compare and count
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Let a number of clock edges pass
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Register write and read through the host model
   task wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask

   task rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, q);
   endtask

   // Read status word one against the expected word
   task rd_stat;
      rd(dsf_pkg::DSF_ADDR_STATUS1);
      check("status1", q, {19'h0, ev.adc_fifo_has_data, st, ~ev.dac_fifo_full, ~ev.dac_fifo_half,
         ~ev.dac_fifo_empty, pdata, pcs, ev.cfg_mem_has_data});
   endtask

   // Pulse events for one cycle, then let one edge pass
   task pulse(input logic [12:0] m);
      @(posedge clk_i);
      ev <= dsf_pkg::dsf_events_type'(ev | m);
      @(posedge clk_i);
      ev <= dsf_pkg::dsf_events_type'(ev & ~m);
      @(posedge clk_i);
   endtask

   // Verdict and end of run
   task results;
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      tick(3000);
      err_total++;
      results();
   end

   // Main sequence
   initial
   begin
      ev.dac_fifo_full = 1'b1;
      ev.dac_fifo_half = 1'b1;
      tick(3);
      rst_i <= 1'b0;
      rd_stat();
      rd(dsf_pkg::DSF_ADDR_BUSY);
      check("busy", q, 32'h1);
      rd(8'h40);
      check("unmapped", q, 32'h0);
      // ADC results waiting, conversion interrupt enabled
      wr(dsf_pkg::DSF_ADDR_CTRL, 32'h4);
      rd(dsf_pkg::DSF_ADDR_CTRL);
      check("ctrl", q, 32'h4);
      ev.adc_fifo_has_data <= 1'b1;
      tick(2);
      check("adc_irq", adc_irq, 32'h1);
      rd_stat();
      ev.adc_fifo_has_data <= 1'b0;
      tick(2);
      check("adc_irq", adc_irq, 32'h0);
      rd_stat();
      // Sticky DMA done flags, second read must not clear
      for (int i = 0; i < 2; i++)
      begin
         pulse(i == 0 ? M_DMA_A : M_DMA_B);
         st[5 - i] = 1'b1;
         rd_stat();
         rd_stat();
         wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h1 << i);
         st[5 - i] = 1'b0;
         rd_stat();
      end
      // Conversion into a full FIFO, a foreign clear leaves it set
      ev.adc_fifo_full <= 1'b1;
      pulse(M_CDONE);
      ev.adc_fifo_full <= 1'b0;
      st[3] = 1'b1;
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h1);
      rd_stat();
      check("abort", abort, 32'h1);
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h4);
      st[3] = 1'b0;
      rd_stat();
      // Start while a conversion is in flight
      ev.adc_converting <= 1'b1;
      pulse(M_CSTART);
      ev.adc_converting <= 1'b0;
      pulse(M_CDONE);
      st[2] = 1'b1;
      rd_stat();
      check("abort", abort, 32'h1);
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h4);
      st[2] = 1'b0;
      rd_stat();
      check("abort", abort, 32'h0);
      // Timer request in interrupt mode: room, then trigger pin
      wr(dsf_pkg::DSF_ADDR_CTRL, 32'h1);
      ev.dac_fifo_full <= 1'b0;
      tick(2);
      check("timer_irq", t_irq, 32'h1);
      check("timer_dma", t_dma, 32'h0);
      ev.dac_fifo_full <= 1'b1;
      st[1] = 1'b1;
      rd_stat();
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h8);
      st[1] = 1'b0;
      rd_stat();
      trig_n <= 1'b0;
      tick(3);
      trig_n <= 1'b1;
      tick(3);
      st[1] = 1'b1;
      pulse(M_DWR);
      rd_stat();
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h8);
      st[1] = 1'b0;
      // DMA mode: a DAC write clears the request
      wr(dsf_pkg::DSF_ADDR_CTRL, 32'h2);
      ev.dac_fifo_full <= 1'b0;
      tick(2);
      check("timer_dma", t_dma, 32'h1);
      ev.dac_fifo_full <= 1'b1;
      tick(1);
      pulse(M_DWR);
      rd_stat();
      check("timer_dma", t_dma, 32'h0);
      // DAC sequence done, serviced by either clear
      wr(dsf_pkg::DSF_ADDR_CTRL, 32'h8);
      for (int i = 0; i < 2; i++)
      begin
         ev.dac_seq_run <= 1'b1;
         tick(2);
         rd_stat();
         ev.dac_seq_run <= 1'b0;
         st[0] = 1'b1;
         tick(2);
         rd_stat();
         check("dac_irq", d_irq, 32'h1);
         wr(dsf_pkg::DSF_ADDR_CLEAR, i == 0 ? 32'h10 : 32'h8);
         st[0] = 1'b0;
         rd_stat();
         check("dac_irq", d_irq, 32'h0);
      end
      // DAC FIFO drained empty, sequence ends: software sees an underrun
      ev <= dsf_pkg::dsf_events_type'(ev ^ 13'h003A);
      st[1:0] = 2'b11;
      tick(2);
      ev.dac_seq_run <= 1'b0;
      tick(2);
      rd_stat();
      check("underrun", {30'h0, q[6], q[3]}, 32'h2);
      ev <= dsf_pkg::dsf_events_type'(ev ^ 13'h0038);
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h8);
      st[1:0] = 2'b00;
      rd_stat();
      // PROM pins and configuration memory
      pdata <= 1'b1;
      pcs <= 1'b1;
      ev.cfg_mem_has_data <= 1'b1;
      tick(3);
      rd_stat();
      pcs <= 1'b0;
      pdata <= 1'b0;
      tick(3);
      rd_stat();
      // Calibration and conversion hold the converter busy
      wr(dsf_pkg::DSF_ADDR_CLEAR, 32'h20);
      rd(dsf_pkg::DSF_ADDR_BUSY);
      check("busy", q, 32'h0);
      check("ready", ready, 32'h0);
      tick(CAL + 4);
      rd(dsf_pkg::DSF_ADDR_BUSY);
      check("busy", q, 32'h1);
      ev.adc_converting <= 1'b1;
      tick(2);
      rd(dsf_pkg::DSF_ADDR_BUSY);
      check("busy", q, 32'h0);
      ev.adc_converting <= 1'b0;
      tick(2);
      rd(dsf_pkg::DSF_ADDR_BUSY);
      check("busy", q, 32'h1);
      results();
   end
endmodule
`default_nettype wire
